// ### rtl/ocp_top.v
/*
  Output channel phase configuration: per-channel wide delay, power-down,
  amplitude flag, step halving and clock/SYSREF mode, with divider setting.
  Assumes a simple strobe register port from a configuration master on
  the same clock; one read answer per read strobe, one cycle later.
*/
// The address-and-strobe port and the address map were decided locally.
// Behaviour
// [R01] Wide delay is 9-bit code times 127ps, 512 steps, resetting to zero.
// [R02] Software keeps the wide delay input frequency at or below 4GHz.
// [R03] Power-down resets to 0; 1 powers down output, divider and delay.
// [R04] Channel power-down forces every output of the channel down.
// [R05] Software sets amplitude flag for code 11 outputs on 1.8V supply.
// [R06] Step halving acts only in SYSREF mode, never in clock mode.
// [R07] Full step: one VCO period; only wide codes 4n, 4n+1 valid.
// [R08] Halved step: all wide codes 0..511 valid, code over twice VCO.
// [R09] Software sets halving only with an external VCO below 2GHz.
// [R10] Mode select resets to clock; 1 makes the channel SYSREF.
// [R11] Divider ratio is first times second stage; first code 000 bypasses.
// [R12] All fields load defaults at reset and hold written values.
// [R13] Writing one channel's fields leaves other channels unchanged.
`timescale 1ns/100ps
`include "ocp_defines.vh"
module ocp_top
#(
  parameter NUM_CH = 8,
  parameter OUTS_PER_CH = 2
)
(
  // Clock and reset
  input wire I_SYS_CLK,
  input wire I_RST_N,
  // Register port
  input wire [7:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [7:0] O_RDATA,
  // Per-output power-down requests from the output registers
  input wire [NUM_CH*OUTS_PER_CH-1:0] I_OUT_PD,
  // Channel controls toward the analog side
  output reg [NUM_CH-1:0] O_CH_PD,
  output reg [NUM_CH*OUTS_PER_CH-1:0] O_OUT_PD,
  output reg [NUM_CH-1:0] O_CH_SYSREF,
  output reg [NUM_CH-1:0] O_LOW_SUPPLY_AMP,
  output reg [NUM_CH-1:0] O_STEP_HALF,
  output reg [NUM_CH*13-1:0] O_WIDE_DELAY_UNITS,
  output reg [NUM_CH*5-1:0] O_DIV_FIRST,
  output reg [NUM_CH*13-1:0] O_DIV_SECOND
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Two synchroniser stages; only the second feeds the logic
  reg rst_s1_ff;
  reg rst_s2_ff;
  wire rst_n;

  // Asynchronous assert, two-flop release to avoid recovery hazards
  always @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  // Internal reset for the whole block
  assign rst_n = rst_s2_ff;

  // ----------------------------------------------------------------
  // Address decode: channel in upper bits, register in low two
  // ----------------------------------------------------------------
  // Decoded address fields
  wire [5:0] ch_sel;
  wire [1:0] reg_sel;
  wire ch_hit;
  assign ch_sel = I_ADDR[7:2];
  assign reg_sel = I_ADDR[1:0];
  assign ch_hit = (ch_sel < NUM_CH);

  // ----------------------------------------------------------------
  // Channel instances
  // ----------------------------------------------------------------
  // Held fields of every channel, flattened per channel
  wire [NUM_CH*9-1:0] wide_all;
  wire [NUM_CH-1:0] pd_all;
  wire [NUM_CH-1:0] lsa_all;
  wire [NUM_CH-1:0] half_all;
  wire [NUM_CH-1:0] mode_all;
  wire [NUM_CH*7-1:0] div_all;
  // Derived controls of every channel
  wire [NUM_CH*13-1:0] units_all;
  wire [NUM_CH-1:0] wbad_all;
  wire [NUM_CH-1:0] dbad_all;
  wire [NUM_CH*5-1:0] first_all;
  wire [NUM_CH*13-1:0] second_all;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : g_ch
      wire sel;
      wire wr_hi;
      wire wr_ctl;
      wire wr_dv;
      // Strobes qualified by this channel's index only
      assign sel = ch_hit & (ch_sel == g); // [R13]
      // One field group per strobe, so other groups keep their values
      assign wr_hi = I_WR & sel & (reg_sel == `OCP_REG_WIDE_HI); // [R12]
      assign wr_ctl = I_WR & sel & (reg_sel == `OCP_REG_CTRL);
      assign wr_dv = I_WR & sel & (reg_sel == `OCP_REG_DIV);
      ocp_channel u_ch
      (
        .clk(I_SYS_CLK),
        .rst_n(rst_n),
        .wr_wide_hi(wr_hi),
        .wr_ctrl(wr_ctl),
        .wr_div(wr_dv),
        .wdata(I_WDATA),
        .wide_ff(wide_all[g*9 +: 9]),
        .pd_ff(pd_all[g]),
        .lsa_ff(lsa_all[g]),
        .half_ff(half_all[g]),
        .mode_ff(mode_all[g]),
        .div_ff(div_all[g*7 +: 7]),
        .delay_units(units_all[g*13 +: 13]),
        .wide_bad(wbad_all[g]),
        .div_bad(dbad_all[g]),
        .div_first(first_all[g*5 +: 5]),
        .div_second(second_all[g*13 +: 13])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Read answer and index; the index width caps the channel count at eight
  reg [7:0] nxt_rdata;
  reg [2:0] ci;

  // Unmapped channels read as zero
  always @*
  begin
    nxt_rdata = 8'h00;
    ci = ch_sel[2:0];
    if (I_RD && ch_hit)
    begin
      case (reg_sel)
        `OCP_REG_WIDE_HI: nxt_rdata = wide_all[ci*9+1 +: 8];
        `OCP_REG_CTRL:
        begin
          nxt_rdata[`OCP_CTRL_PD_BIT] = pd_all[ci];
          nxt_rdata[`OCP_CTRL_LSA_BIT] = lsa_all[ci];
          nxt_rdata[`OCP_CTRL_HALF_BIT] = half_all[ci];
          nxt_rdata[`OCP_CTRL_MODE_BIT] = mode_all[ci];
          nxt_rdata[`OCP_CTRL_WIDE0_BIT] = wide_all[ci*9];
        end
        `OCP_REG_DIV: nxt_rdata = {1'b0, div_all[ci*7 +: 7]};
        // Status bits are derived each cycle, never stored
        `OCP_REG_STAT:
        begin
          nxt_rdata[`OCP_STAT_PWR_BIT] = ~pd_all[ci];
          nxt_rdata[`OCP_STAT_SYSREF_BIT] = mode_all[ci];
          nxt_rdata[`OCP_STAT_HALF_BIT] = half_all[ci] & mode_all[ci]; // [R06]
          nxt_rdata[`OCP_STAT_WBAD_BIT] = wbad_all[ci]; // [R07]
          nxt_rdata[`OCP_STAT_DBAD_BIT] = dbad_all[ci];
        end
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Loop index and the forced per-output power-down
  integer k;
  reg [NUM_CH*OUTS_PER_CH-1:0] nxt_out_pd;

  // Channel power-down overrides each output's own request
  always @*
  begin
    nxt_out_pd = I_OUT_PD;
    for (k = 0; k < NUM_CH*OUTS_PER_CH; k = k + 1)
      if (pd_all[k/OUTS_PER_CH])
        nxt_out_pd[k] = 1'b1; // [R04]
  end

  // Per-output requests come from same-clock logic, so no synchroniser
  always @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_RDATA <= 8'h00;
      O_CH_PD <= {NUM_CH{1'b0}};
      O_OUT_PD <= {NUM_CH*OUTS_PER_CH{1'b0}};
      O_CH_SYSREF <= {NUM_CH{1'b0}};
      O_LOW_SUPPLY_AMP <= {NUM_CH{1'b0}};
      O_STEP_HALF <= {NUM_CH{1'b0}};
      O_WIDE_DELAY_UNITS <= {NUM_CH*13{1'b0}};
      O_DIV_FIRST <= {NUM_CH{5'h01}};
      O_DIV_SECOND <= {NUM_CH{13'h0001}};
    end
    else
    begin
      O_RDATA <= nxt_rdata;
      O_CH_PD <= pd_all; // [R03]
      O_OUT_PD <= nxt_out_pd; // [R04]
      O_CH_SYSREF <= mode_all; // [R10]
      O_LOW_SUPPLY_AMP <= lsa_all;
      O_STEP_HALF <= half_all & mode_all; // [R06]
      O_WIDE_DELAY_UNITS <= units_all; // [R01] [R08]
      O_DIV_FIRST <= first_all; // [R11]
      O_DIV_SECOND <= second_all; // [R11]
    end
  end
endmodule // ocp_top

// ### inc/ocp_defines.vh
/*
  Constants for the output channel phase configuration block: register
  offsets, field positions, reset values and timing figures.
  Assumes inclusion by bare name from the rtl files.
*/
`ifndef OCP_DEFINES_VH
`define OCP_DEFINES_VH

// ----------------------------------------------------------------
// Register map, four registers per channel
// ----------------------------------------------------------------
`define OCP_ADDR_W 8
`define OCP_DATA_W 8
`define OCP_REG_WIDE_HI 2'h0
`define OCP_REG_CTRL 2'h1
`define OCP_REG_DIV 2'h2
`define OCP_REG_STAT 2'h3
// Control register fields
`define OCP_CTRL_PD_BIT 7
`define OCP_CTRL_LSA_BIT 6
`define OCP_CTRL_HALF_BIT 4
`define OCP_CTRL_MODE_BIT 1
`define OCP_CTRL_WIDE0_BIT 0
// Status register fields
`define OCP_STAT_PWR_BIT 0
`define OCP_STAT_SYSREF_BIT 1
`define OCP_STAT_HALF_BIT 2
`define OCP_STAT_WBAD_BIT 3
`define OCP_STAT_DBAD_BIT 4
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OCP_WIDE_RST 9'h000
`define OCP_DIV_RST 7'h0B
// ----------------------------------------------------------------
// Delay step figures in picoseconds, then divider code limits
// ----------------------------------------------------------------
`define OCP_WIDE_STEP_PS 127
`define OCP_VCO_PERIOD_PS 254
`define OCP_HALF_STEP_PS 127
`define OCP_FIRST_BYPASS 3'h0
`define OCP_FIRST_MAX 3'h4
`define OCP_SECOND_MAX 4'hC
`endif

// ### rtl/ocp_channel.v
/*
  One output channel's configuration fields and derived controls.
  Assumes an active-low reset whose release is already synchronised.
*/
`timescale 1ns/100ps
`include "ocp_defines.vh"
module ocp_channel
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Field writes
  input wire wr_wide_hi,
  input wire wr_ctrl,
  input wire wr_div,
  input wire [7:0] wdata,
  // Held fields
  output reg [8:0] wide_ff,
  output reg pd_ff,
  output reg lsa_ff,
  output reg half_ff,
  output reg mode_ff,
  output reg [6:0] div_ff,
  // Derived controls
  output wire [12:0] delay_units,
  output wire wide_bad,
  output wire div_bad,
  output wire [4:0] div_first,
  output wire [12:0] div_second
);
  wire step_half;
  wire [2:0] first_code;
  wire [3:0] second_code;

  // Field storage; only this channel's strobes reach it
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wide_ff <= `OCP_WIDE_RST; // [R01] [R12]
      pd_ff <= 1'b0; // [R03] [R12]
      lsa_ff <= 1'b0;
      half_ff <= 1'b0;
      mode_ff <= 1'b0; // [R10]
      div_ff <= `OCP_DIV_RST; // [R12]
    end
    else
    begin
      if (wr_wide_hi)
        wide_ff[8:1] <= wdata; // [R13]
      if (wr_ctrl)
      begin
        pd_ff <= wdata[`OCP_CTRL_PD_BIT]; // [R03]
        lsa_ff <= wdata[`OCP_CTRL_LSA_BIT];
        half_ff <= wdata[`OCP_CTRL_HALF_BIT];
        mode_ff <= wdata[`OCP_CTRL_MODE_BIT];
        wide_ff[0] <= wdata[`OCP_CTRL_WIDE0_BIT];
      end
      if (wr_div)
        div_ff <= wdata[6:0];
    end
  end

  // Halving only counts in SYSREF mode
  assign step_half = half_ff & mode_ff; // [R06]
  // Delay in half VCO periods: full step doubles the code
  assign delay_units = step_half ? {4'h0, wide_ff} : {3'h0, wide_ff, 1'b0}; // [R07] [R08]
  // Full-step mode accepts codes 4n and 4n+1 only, top pair 508 and 509 included
  assign wide_bad = !step_half & (wide_ff[1] | (wide_ff[7:1] == 7'h7F)); // [R07]
  assign first_code = div_ff[2:0];
  assign second_code = div_ff[6:3];
  // First stage ratio is code+1; code zero bypasses the second stage
  assign div_first = {2'h0, first_code} + 5'h01; // [R11]
  assign div_second = (first_code == `OCP_FIRST_BYPASS) ? 13'h0001 :
                      (13'h0001 << second_code); // [R11]
  assign div_bad = (first_code > `OCP_FIRST_MAX) | (second_code > `OCP_SECOND_MAX);
endmodule // ocp_channel

// ### testbench/ocp_monitor.sv
/*
  Checker for ocp_top: mirrors register writes, ties outputs to them.
  Assumes a bind onto ocp_top and a single clock domain.
*/
`timescale 1ns/100ps
module ocp_monitor
#(
  parameter NUM_CH = 8,
  parameter OUTS_PER_CH = 2
)
(
  // Clock, reset and bus
  input wire I_SYS_CLK,
  input wire I_RST_N,
  input wire [7:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire [NUM_CH*OUTS_PER_CH-1:0] I_OUT_PD,
  // Watched outputs
  input wire [7:0] O_RDATA,
  input wire [NUM_CH-1:0] O_CH_PD,
  input wire [NUM_CH*OUTS_PER_CH-1:0] O_OUT_PD,
  input wire [NUM_CH-1:0] O_CH_SYSREF,
  input wire [NUM_CH-1:0] O_LOW_SUPPLY_AMP,
  input wire [NUM_CH-1:0] O_STEP_HALF,
  input wire [NUM_CH*13-1:0] O_WIDE_DELAY_UNITS,
  input wire [NUM_CH*5-1:0] O_DIV_FIRST,
  input wire [NUM_CH*13-1:0] O_DIV_SECOND
);
  // --------
  // Register mirror
  // --------
  logic [3:0] up_ff;
  logic wr_ff;
  logic rd_ff;
  logic [5:0] ch_ff;
  logic [1:0] reg_ff;
  logic [7:0] d_ff;
  logic [NUM_CH-1:0][7:0] hi_ff;
  logic [NUM_CH-1:0][7:0] ctl_ff;
  logic [NUM_CH-1:0][6:0] div_ff;
  logic [NUM_CH*OUTS_PER_CH-1:0] pd_wide;
  wire live = up_ff[3];
  wire wmap = wr_ff && ch_ff < NUM_CH;

  // One cycle behind the bus; live waits out the reset synchroniser
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      up_ff <= 4'h0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      hi_ff <= '0;
      ctl_ff <= '0;
      div_ff <= {NUM_CH{7'h0B}};
    end
    else
    begin
      up_ff <= {up_ff[2:0], 1'b1};
      wr_ff <= I_WR;
      rd_ff <= I_RD;
      ch_ff <= I_ADDR[7:2];
      reg_ff <= I_ADDR[1:0];
      d_ff <= I_WDATA;
      if (wmap && reg_ff == 2'h0)
        hi_ff[ch_ff] <= d_ff;
      if (wmap && reg_ff == 2'h1)
        ctl_ff[ch_ff] <= d_ff;
      if (wmap && reg_ff == 2'h2)
        div_ff[ch_ff] <= d_ff[6:0];
    end
  end

  // Channel power-down spread over its outputs
  for (genvar i = 0; i < NUM_CH*OUTS_PER_CH; i++)
  begin : g_pd
    assign pd_wide[i] = O_CH_PD[i/OUTS_PER_CH];
  end

  // --------
  // Assertions
  // --------
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);

  AST_OUT_PD: assert property (live |-> O_OUT_PD == ($past(I_OUT_PD) | pd_wide))
    else $error("output power-down not forced");
  AST_RD_HI: assert property (rd_ff && ch_ff < NUM_CH && reg_ff == 2'h0 |-> O_RDATA == hi_ff[ch_ff])
    else $error("wide delay readback wrong");
  AST_RD_IDLE: assert property (!rd_ff || ch_ff >= NUM_CH |-> O_RDATA == 8'h00)
    else $error("read data not zero");

  // Per channel, outputs follow that channel's mirror only
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    wire half = ctl_ff[c][4] && ctl_ff[c][1];
    wire [8:0] code = {hi_ff[c], ctl_ff[c][0]};
    wire [12:0] units = half ? {4'h0, code} : {3'h0, code, 1'b0};
    wire [6:0] dv = div_ff[c];
    wire ok_div = dv[2:0] < 3'h5 && dv[6:3] < 4'hD;
    wire [12:0] sec = dv[2:0] == 3'h0 ? 13'h0001 : 13'h0001 << dv[6:3];
    AST_PD: assert property (live |-> O_CH_PD[c] == ctl_ff[c][7])
      else $error("channel power-down wrong");
    AST_MODE: assert property (live |-> O_CH_SYSREF[c] == ctl_ff[c][1] && O_LOW_SUPPLY_AMP[c] == ctl_ff[c][6])
      else $error("mode or amplitude flag wrong");
    AST_HALF: assert property (live |-> O_STEP_HALF[c] == half)
      else $error("step halving wrong");
    AST_UNITS: assert property (live |-> O_WIDE_DELAY_UNITS[13*c+:13] == units)
      else $error("wide delay units wrong");
    AST_DIV: assert property (live && ok_div |-> O_DIV_FIRST[5*c+:5] == {2'h0, dv[2:0]} + 5'h01
      && O_DIV_SECOND[13*c+:13] == sec)
      else $error("divider ratio wrong");
  end

  COV_PD: cover property (wmap && reg_ff == 2'h1 && d_ff[7]);
  COV_HALF: cover property (|O_STEP_HALF);
  COV_RD: cover property (rd_ff && reg_ff == 2'h3);
endmodule // ocp_monitor

bind ocp_top ocp_monitor #(.NUM_CH(NUM_CH), .OUTS_PER_CH(OUTS_PER_CH)) i_mon (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .I_OUT_PD(I_OUT_PD), .O_RDATA(O_RDATA), .O_CH_PD(O_CH_PD), .O_OUT_PD(O_OUT_PD),
  .O_CH_SYSREF(O_CH_SYSREF), .O_LOW_SUPPLY_AMP(O_LOW_SUPPLY_AMP), .O_STEP_HALF(O_STEP_HALF),
  .O_WIDE_DELAY_UNITS(O_WIDE_DELAY_UNITS), .O_DIV_FIRST(O_DIV_FIRST), .O_DIV_SECOND(O_DIV_SECOND));

// ### testbench/output_channel_phase_config_tb_top.sv
/*
  Bench for ocp_top: one task per scenario drives the register port
  and judges the channel outputs. Assumes ocp_monitor is compiled too.
*/
`timescale 1ns/100ps
module output_channel_phase_config_tb_top;
  // --------
  // Signals
  // --------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] out_pd = 16'h0000;
  logic [7:0] rdata, ch_pd, sysref, lsa, half;
  logic [15:0] o_pd;
  logic [103:0] units, second;
  logic [39:0] first;
  int bad_count = 0;
  int tests_run = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  ocp_top i_dut (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_OUT_PD(out_pd), .O_CH_PD(ch_pd), .O_OUT_PD(o_pd), .O_CH_SYSREF(sysref),
    .O_LOW_SUPPLY_AMP(lsa), .O_STEP_HALF(half), .O_WIDE_DELAY_UNITS(units), .O_DIV_FIRST(first),
    .O_DIV_SECOND(second));

  // --------
  // Bus and compare tasks
  // --------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check({8'h00, rdata}, {8'h00, exp});
  endtask

  // Derived outputs land one edge after the write edge
  task automatic settle;
    @(posedge clk);
    #1;
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_defaults;
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h02, 8'h0B);
    rd_chk(8'h03, 8'h01);
    check(16'(first[4:0]), 16'h0004);
    check(16'(second[12:0]), 16'h0002);
    check(16'(sysref), 16'h0000);
  endtask

  task automatic t_power;
    wr_reg(8'h05, 8'hC0);
    settle;
    check(16'(ch_pd), 16'h0002);
    check(16'(lsa), 16'h0002);
    check(o_pd, 16'h000C);
    @(posedge clk);
    out_pd <= 16'h0005;
    settle;
    check(o_pd, 16'h000D);
    rd_chk(8'h07, 8'h00);
    wr_reg(8'h05, 8'h00);
    settle;
    check(o_pd, 16'h0005);
  endtask

  task automatic t_halving;
    wr_reg(8'h08, 8'h02);
    wr_reg(8'h09, 8'h11);
    settle;
    check(16'(half), 16'h0000);
    check(16'(units[38:26]), 16'h000A);
    wr_reg(8'h09, 8'h13);
    settle;
    check(16'(half), 16'h0004);
    check(16'(units[38:26]), 16'h0005);
    check(16'(sysref), 16'h0004);
    rd_chk(8'h0B, 8'h07);
    wr_reg(8'h09, 8'h03);
    settle;
    check(16'(units[38:26]), 16'h000A);
  endtask

  task automatic t_codes;
    wr_reg(8'h0C, 8'h01);
    rd_chk(8'h0F, 8'h09);
    wr_reg(8'h0D, 8'h12);
    rd_chk(8'h0F, 8'h07);
    wr_reg(8'h0C, 8'hFF);
    wr_reg(8'h0D, 8'h01);
    settle;
    check(16'(units[51:39]), 16'h03FE);
    rd_chk(8'h0F, 8'h09);
  endtask

  task automatic t_divider;
    logic [7:0] code [4] = '{8'h00, 8'h24, 8'h62, 8'h60};
    logic [15:0] f_exp [4] = '{16'h0001, 16'h0005, 16'h0003, 16'h0001};
    logic [15:0] s_exp [4] = '{16'h0001, 16'h0010, 16'h1000, 16'h0001};
    foreach (code[i])
    begin
      wr_reg(8'h12, code[i]);
      settle;
      check(16'(first[24:20]), f_exp[i]);
      check(16'(second[64:52]), s_exp[i]);
    end
    wr_reg(8'h12, 8'h07);
    rd_chk(8'h13, 8'h11);
  endtask

  task automatic t_unmapped;
    wr_reg(8'h80, 8'hFF);
    wr_reg(8'h81, 8'hFF);
    rd_chk(8'h80, 8'h00);
    rd_chk(8'h00, 8'h00);
    check(16'(ch_pd), 16'h0000);
  endtask

  // --------
  // Run control
  // --------
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence after a 16-cycle reset
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_defaults;
    t_power;
    t_halving;
    t_codes;
    t_divider;
    t_unmapped;
    complete_run;
  end

  // Watchdog, far beyond the hundred or so cycles the run needs
  initial
  begin
    #20000;
    bad_count++;
    complete_run;
  end
endmodule // output_channel_phase_config_tb_top
